// [hw/elao_top.sv]
// Purpose: execute table read, xor and extended data-memory instructions
// Assumes: one instruction per valid cycle; results long_and_acc on the next edge
// Notes: local data memory split into sections; ordinary ops use cur_section
// How it works
// - table read: low byte to memory, high to latch
// - xor with memory into acc, zero flag only
// - xor acc into memory byte, zero flag only
// - xor literal into acc, zero flag only
// - extended ops address any section directly
// - add with carry into acc, arithmetic flags
// - add with carry into memory, arithmetic flags
// - add into acc without carry, arithmetic flags
// - add into memory without carry, arithmetic flags
// - and with memory into acc, zero flag
// - and acc into memory byte, zero flag
// - clear memory byte, flags unchanged
// - clear one selected bit, flags unchanged
`timescale 1ns/1ps
`default_nettype none
`include "elao_defs.svh"

module elao_top
   import elao_pkg::*;
(
   input  wire logic                    clock,
   input  wire logic                    reset,
   input  wire elao_instr_s             instr,
   input  wire logic [`ELAO_SECT_W-1:0] cur_section,
   output logic      [`ELAO_BYTE_W-1:0] acc_q,
   output elao_flags_s                  flags_q,
   output logic      [`ELAO_BYTE_W-1:0] table_high_latch_q,
   output elao_wr_s                     mem_wr_q,
   output logic                         done_q
);

   logic [`ELAO_BYTE_W-1:0] mem_q [`ELAO_MEM_WORDS];

   function automatic logic is_extended(input elao_op_e op);
      is_extended = (op >= OP_LONG_ADD_CARRY_ACC) && (op <= OP_LONG_CLEAR_BIT);
   endfunction

   function automatic logic is_zero(input logic [`ELAO_BYTE_W-1:0] v);
      is_zero = (v == `ELAO_ZERO_BYTE);
   endfunction

   wire                          go = instr.valid;
   wire                          ext = is_extended(instr.op);
   wire [`ELAO_SECT_W-1:0]       sect = ext ? instr.section : cur_section;
   wire [`ELAO_ADDR_W-1:0]       addr = {sect, instr.offset};
   wire [`ELAO_BYTE_W-1:0]       rd_data = mem_q[addr];
   wire                          use_cin = (instr.op == OP_LONG_ADD_CARRY_ACC)
                                        || (instr.op == OP_LONG_ADD_CARRY_MEM);
   wire                          cin = use_cin & flags_q.carry_flag;
   wire [`ELAO_BYTE_W-1:0]       opnd = (instr.op == OP_XOR_IMM) ? instr.literal : rd_data;
   wire [`ELAO_BYTE_W-1:0]       bit_mask = 8'h01 << instr.bit_sel;

   logic [`ELAO_BYTE_W-1:0] sum;
   logic [`ELAO_BYTE_W-1:0] and_out;
   logic [`ELAO_BYTE_W-1:0] xor_out;
   elao_flags_s             add_flags;

   elao_alu u_alu
   (
      .a         (acc_q),
      .b         (opnd),
      .carry_in  (cin),
      .sum       (sum),
      .and_out   (and_out),
      .xor_out   (xor_out),
      .add_flags (add_flags)
   );

   logic [`ELAO_BYTE_W-1:0] result;
   logic                    to_acc;
   logic                    to_mem;
   elao_kind_e              kind;

   always_comb
   begin
      result = `ELAO_ZERO_BYTE;
      to_acc = 1'b0;
      to_mem = 1'b0;
      kind   = KIND_NONE;
      case (instr.op)
         OP_TABLE_READ:
         begin
            result = instr.prog_word[`ELAO_BYTE_W-1:0];
            to_mem = 1'b1;
         end
         OP_XOR_ACC, OP_XOR_IMM:
         begin
            result = xor_out;
            to_acc = 1'b1;
            kind   = KIND_LOGIC;
         end
         OP_XOR_TO_MEMORY:
         begin
            result = xor_out;
            to_mem = 1'b1;
            kind   = KIND_LOGIC;
         end
         OP_LONG_ADD_CARRY_ACC, OP_LONG_ADD_ACC:
         begin
            result = sum;
            to_acc = 1'b1;
            kind   = KIND_ADD;
         end
         OP_LONG_ADD_CARRY_MEM, OP_LONG_ADD_MEM:
         begin
            result = sum;
            to_mem = 1'b1;
            kind   = KIND_ADD;
         end
         OP_LONG_AND_ACC:
         begin
            result = and_out;
            to_acc = 1'b1;
            kind   = KIND_LOGIC;
         end
         OP_LONG_AND_MEM:
         begin
            result = and_out;
            to_mem = 1'b1;
            kind   = KIND_LOGIC;
         end
         OP_LONG_CLEAR_BYTE:
         begin
            result = `ELAO_ZERO_BYTE;
            to_mem = 1'b1;
         end
         OP_LONG_CLEAR_BIT:
         begin
            result = rd_data & ~bit_mask;
            to_mem = 1'b1;
         end
         default:
         begin
            result = `ELAO_ZERO_BYTE;
         end
      endcase
   end

   // logic ops touch only the zero flag; adds load all flags from the alu; others keep all flags
   elao_flags_s flags_d;
   always_comb
   begin
      flags_d = flags_q;
      case (kind)
         KIND_ADD:   flags_d = add_flags;
         KIND_LOGIC: flags_d.zero_flag = is_zero(result);
         default:    flags_d = flags_q;
      endcase
   end

   wire mem_we = go & to_mem;

   always_ff @(posedge clock or posedge reset)
   begin
      if (reset)
      begin
         acc_q              <= `ELAO_ACC_RST;
         flags_q            <= '0;
         table_high_latch_q <= `ELAO_LATCH_RST;
         mem_wr_q           <= '0;
         done_q             <= 1'b0;
      end
      else
      begin
         done_q       <= go;
         mem_wr_q.en  <= mem_we;
         if (go)
         begin
            mem_wr_q.addr <= addr;
            mem_wr_q.data <= result;
            flags_q       <= flags_d;
         end
         if (go && to_acc)
            acc_q <= result;
         if (go && instr.op == OP_TABLE_READ)
            table_high_latch_q <= instr.prog_word[2*`ELAO_BYTE_W-1:`ELAO_BYTE_W];
      end
   end

   // memory holds no reset; contents are software state
   always_ff @(posedge clock)
   begin
      if (mem_we)
         mem_q[addr] <= result;
   end

   wire op_logic = go && (instr.op inside {OP_XOR_ACC, OP_XOR_TO_MEMORY, OP_XOR_IMM,
                                           OP_LONG_AND_ACC, OP_LONG_AND_MEM});
   wire op_quiet = go && (instr.op inside {OP_TABLE_READ, OP_LONG_CLEAR_BYTE,
                                           OP_LONG_CLEAR_BIT});

   property p_table_read;
      @(posedge clock) disable iff (reset)
      (go && instr.op == OP_TABLE_READ) |=>
         mem_wr_q.en && mem_wr_q.data == $past(instr.prog_word[`ELAO_BYTE_W-1:0])
         && table_high_latch_q == $past(instr.prog_word[2*`ELAO_BYTE_W-1:`ELAO_BYTE_W]);
   endproperty
   a_table_read: assert property (p_table_read) else $error("table read mismatch");

   property p_xor_acc;
      @(posedge clock) disable iff (reset)
      (go && instr.op == OP_XOR_ACC) |=> acc_q == ($past(acc_q) ^ $past(rd_data));
   endproperty
   a_xor_acc: assert property (p_xor_acc) else $error("xor to acc wrong");

   property p_xor_mem;
      @(posedge clock) disable iff (reset)
      (go && instr.op == OP_XOR_TO_MEMORY) |=>
         mem_wr_q.en && mem_wr_q.data == ($past(acc_q) ^ $past(rd_data))
         && $stable(acc_q);
   endproperty
   a_xor_mem: assert property (p_xor_mem) else $error("xor to memory wrong");

   property p_xor_imm;
      @(posedge clock) disable iff (reset)
      (go && instr.op == OP_XOR_IMM) |=> acc_q == ($past(acc_q) ^ $past(instr.literal));
   endproperty
   a_xor_imm: assert property (p_xor_imm) else $error("xor immediate wrong");

   property p_ext_addr;
      @(posedge clock) disable iff (reset)
      (go && ext && to_mem) |=> mem_wr_q.addr[`ELAO_ADDR_W-1:`ELAO_OFF_W] == $past(instr.section);
   endproperty
   a_ext_addr: assert property (p_ext_addr) else $error("extended section ignored");

   property p_add_carry;
      @(posedge clock) disable iff (reset)
      (go && instr.op == OP_LONG_ADD_CARRY_ACC) |=>
         {flags_q.carry_flag, acc_q} == {1'b0, $past(acc_q)} + {1'b0, $past(rd_data)}
                                       + {{`ELAO_BYTE_W{1'b0}}, $past(flags_q.carry_flag)};
   endproperty
   a_add_carry: assert property (p_add_carry) else $error("add with carry wrong");

   property p_add_mem;
      @(posedge clock) disable iff (reset)
      (go && instr.op == OP_LONG_ADD_MEM) |=>
         mem_wr_q.data == 8'($past(acc_q) + $past(rd_data)) && $stable(acc_q);
   endproperty
   a_add_mem: assert property (p_add_mem) else $error("add to memory wrong");

   property p_and_mem;
      @(posedge clock) disable iff (reset)
      (go && instr.op == OP_LONG_AND_MEM) |=>
         mem_wr_q.data == ($past(acc_q) & $past(rd_data));
   endproperty
   a_and_mem: assert property (p_and_mem) else $error("and to memory wrong");

   property p_quiet_flags;
      @(posedge clock) disable iff (reset)
      op_quiet |=> $stable(flags_q);
   endproperty
   a_quiet_flags: assert property (p_quiet_flags) else $error("flags moved");

   property p_clear_bit;
      @(posedge clock) disable iff (reset)
      (go && instr.op == OP_LONG_CLEAR_BIT) |=>
         mem_wr_q.data == ($past(rd_data) & ~$past(bit_mask));
   endproperty
   a_clear_bit: assert property (p_clear_bit) else $error("clear bit wrong");

   property p_zero_flag;
      @(posedge clock) disable iff (reset)
      op_logic |=> flags_q.zero_flag == is_zero($past(result))
         && flags_q.carry_flag == $past(flags_q.carry_flag);
   endproperty
   a_zero_flag: assert property (p_zero_flag) else $error("zero flag wrong");

   property p_cov_carry_chain;
      @(posedge clock) disable iff (reset)
      (go && instr.op == OP_LONG_ADD_ACC) ##1 (go && instr.op == OP_LONG_ADD_CARRY_ACC);
   endproperty
   c_carry_chain: cover property (p_cov_carry_chain);

   property p_cov_overflow;
      @(posedge clock) disable iff (reset)
      flags_q.signed_wrap_flag;
   endproperty
   c_overflow: cover property (p_cov_overflow);

   property p_cov_other_section;
      @(posedge clock) disable iff (reset)
      go && ext && instr.section != cur_section;
   endproperty
   c_other_section: cover property (p_cov_other_section);

endmodule
`default_nettype wire

// [hw/elao_defs.svh]
// Purpose: named constants for the extended logic/arith datapath
// Assumes: included by bare name; definitions only
// Notes: section and offset widths size the local data memory
`ifndef ELAO_DEFS_SVH
`define ELAO_DEFS_SVH

`define ELAO_SECT_W     2
`define ELAO_OFF_W      7
`define ELAO_ADDR_W     9
`define ELAO_MEM_WORDS  512
`define ELAO_BYTE_W     8
`define ELAO_SIGN_BIT   7
`define ELAO_NIB_W      4
`define ELAO_ZERO_BYTE  8'h00
`define ELAO_ACC_RST    8'h00
`define ELAO_LATCH_RST  8'h00

`endif

// [hw/elao_pkg.sv]
// Purpose: types shared by the datapath and its arithmetic unit
// Assumes: elao_defs.svh supplies widths
// Notes: operation codes are written out in binary
`include "elao_defs.svh"

package elao_pkg;

   typedef enum logic [3:0]
   {
      OP_TABLE_READ          = 4'b0000,
      OP_XOR_ACC             = 4'b0001,
      OP_XOR_TO_MEMORY       = 4'b0010,
      OP_XOR_IMM             = 4'b0011,
      OP_LONG_ADD_CARRY_ACC  = 4'b0100,
      OP_LONG_ADD_CARRY_MEM  = 4'b0101,
      OP_LONG_ADD_ACC        = 4'b0110,
      OP_LONG_ADD_MEM        = 4'b0111,
      OP_LONG_AND_ACC        = 4'b1000,
      OP_LONG_AND_MEM        = 4'b1001,
      OP_LONG_CLEAR_BYTE     = 4'b1010,
      OP_LONG_CLEAR_BIT      = 4'b1011,
      OP_NOP                 = 4'b1111
   } elao_op_e;

   typedef enum logic [1:0]
   {
      KIND_LOGIC = 2'b00,
      KIND_ADD   = 2'b01,
      KIND_NONE  = 2'b10
   } elao_kind_e;

   typedef struct packed
   {
      logic signed_wrap_flag;
      logic zero_flag;
      logic nibble_carry_flag;
      logic carry_flag;
      logic result_sign_flag;
   } elao_flags_s;

   typedef struct packed
   {
      logic                       valid;
      elao_op_e                   op;
      logic [`ELAO_SECT_W-1:0]    section;
      logic [`ELAO_OFF_W-1:0]     offset;
      logic [2:0]                 bit_sel;
      logic [`ELAO_BYTE_W-1:0]    literal;
      logic [2*`ELAO_BYTE_W-1:0]  prog_word;
   } elao_instr_s;

   typedef struct packed
   {
      logic                       en;
      logic [`ELAO_ADDR_W-1:0]    addr;
      logic [`ELAO_BYTE_W-1:0]    data;
   } elao_wr_s;

endpackage

// [hw/elao_alu.sv]
// Purpose: eight-bit add and logic unit with flag generation
// Assumes: purely combinational; caller selects which flags to keep
// Notes: sign flag is the sign of the true nine-bit signed sum
`timescale 1ns/1ps
`default_nettype none
`include "elao_defs.svh"

module elao_alu
   import elao_pkg::*;
(
   input  wire logic [`ELAO_BYTE_W-1:0] a,
   input  wire logic [`ELAO_BYTE_W-1:0] b,
   input  wire logic                    carry_in,
   output logic      [`ELAO_BYTE_W-1:0] sum,
   output logic      [`ELAO_BYTE_W-1:0] and_out,
   output logic      [`ELAO_BYTE_W-1:0] xor_out,
   output elao_flags_s                  add_flags
);

   logic [`ELAO_BYTE_W:0] sum_wide;
   logic [`ELAO_NIB_W:0]  nib_wide;
   logic                  wrap;

   assign sum_wide = {1'b0, a} + {1'b0, b} + {{`ELAO_BYTE_W{1'b0}}, carry_in};
   assign nib_wide = {1'b0, a[`ELAO_NIB_W-1:0]} + {1'b0, b[`ELAO_NIB_W-1:0]}
                   + {{`ELAO_NIB_W{1'b0}}, carry_in};
   assign sum      = sum_wide[`ELAO_BYTE_W-1:0];
   assign and_out  = a & b;
   assign xor_out  = a ^ b;
   // overflow: operands agree in sign, result disagrees
   assign wrap     = (a[`ELAO_SIGN_BIT] == b[`ELAO_SIGN_BIT])
                   && (sum[`ELAO_SIGN_BIT] != a[`ELAO_SIGN_BIT]);

   assign add_flags.signed_wrap_flag  = wrap;
   assign add_flags.zero_flag         = (sum == `ELAO_ZERO_BYTE);
   assign add_flags.nibble_carry_flag = nib_wide[`ELAO_NIB_W];
   assign add_flags.carry_flag        = sum_wide[`ELAO_BYTE_W];
   assign add_flags.result_sign_flag  = wrap ^ sum[`ELAO_SIGN_BIT];

endmodule
`default_nettype wire

// [verification/test_extended_logic_arith_ops.sv]
// Purpose: self-checking bench for the extended logic/arith datapath
// Assumes: inputs change on the falling edge; results long_and_acc on the next rising edge
// Notes: data memory has no read port, so the bench keeps a shadow copy
`timescale 1ns/1ps
`default_nettype none

module test_extended_logic_arith_ops
   import elao_pkg::*;
;
   logic        clock;
   logic        reset;
   elao_instr_s instr;
   logic [1:0]  cur_section;
   logic [7:0]  acc_q;
   elao_flags_s flags_q;
   logic [7:0]  table_high_latch_q;
   elao_wr_s    mem_wr_q;
   logic        done_q;
   int          n_mismatch;
   int          samples_checked;
   logic [7:0]  acc_m;
   logic [7:0]  latch_m;
   elao_flags_s flags_m;
   logic [7:0]  mem_m [512];

   elao_top uut
   (
      .clock              (clock),
      .reset              (reset),
      .instr              (instr),
      .cur_section        (cur_section),
      .acc_q              (acc_q),
      .flags_q            (flags_q),
      .table_high_latch_q (table_high_latch_q),
      .mem_wr_q           (mem_wr_q),
      .done_q             (done_q)
   );

   initial
   begin
      clock = 1'b0;
      forever #2.5 clock = ~clock;
   end

   task automatic check_val(input string what, input logic [8:0] exp, input logic [8:0] got);
      samples_checked++;
      if (got !== exp)
      begin
         n_mismatch++;
         $display("[FAIL] %s expected %h seen %h", what, exp, got);
      end
   endtask

   // issues one instruction and leaves valid high, so calls run back to back
   task automatic exec(input elao_op_e op, input logic [1:0] sec, input logic [6:0] off,
                       input logic [7:0] lit, input logic [15:0] pw, input logic [2:0] bs);
      logic [8:0]  a;
      logic [8:0]  s;
      logic [4:0]  n;
      logic [7:0]  m;
      logic [7:0]  r;
      logic        c;
      logic        wrp;
      logic        wr;
      elao_flags_s fa;
      a = (op >= OP_LONG_ADD_CARRY_ACC) ? {sec, off} : {cur_section, off};
      m = mem_m[a];
      r = 8'h00;
      wr = 1'b0;
      c = (op == OP_LONG_ADD_CARRY_ACC || op == OP_LONG_ADD_CARRY_MEM) ? flags_m.carry_flag : 1'b0;
      s = {1'b0, acc_m} + {1'b0, m} + {8'h00, c};
      n = {1'b0, acc_m[3:0]} + {1'b0, m[3:0]} + {4'h0, c};
      wrp = (acc_m[7] == m[7]) && (s[7] != acc_m[7]);
      fa = '{wrp, s[7:0] == 8'h00, n[4], s[8], wrp ^ s[7]};
      case (op)
         OP_TABLE_READ:                          {wr, r, latch_m} = {1'b1, pw[7:0], pw[15:8]};
         OP_XOR_ACC:                             acc_m = acc_m ^ m;
         OP_XOR_TO_MEMORY:                       {wr, r} = {1'b1, acc_m ^ m};
         OP_XOR_IMM:                             acc_m = acc_m ^ lit;
         OP_LONG_AND_ACC:                        acc_m = acc_m & m;
         OP_LONG_AND_MEM:                        {wr, r} = {1'b1, acc_m & m};
         OP_LONG_CLEAR_BYTE:                     wr = 1'b1;
         OP_LONG_CLEAR_BIT:                      {wr, r} = {1'b1, m & ~(8'h01 << bs)};
         OP_LONG_ADD_CARRY_ACC, OP_LONG_ADD_ACC: acc_m = s[7:0];
         OP_LONG_ADD_CARRY_MEM, OP_LONG_ADD_MEM: {wr, r} = {1'b1, s[7:0]};
         default:                                wr = 1'b0;
      endcase
      if (op >= OP_LONG_ADD_CARRY_ACC && op <= OP_LONG_ADD_MEM)
         flags_m = fa;
      if (op inside {OP_XOR_ACC, OP_XOR_IMM, OP_LONG_AND_ACC})
         flags_m.zero_flag = (acc_m == 8'h00);
      if (op inside {OP_XOR_TO_MEMORY, OP_LONG_AND_MEM})
         flags_m.zero_flag = (r == 8'h00);
      if (wr)
         mem_m[a] = r;
      instr = '{1'b1, op, sec, off, bs, lit, pw};
      @(negedge clock);
      check_val("done_q", 9'h001, {8'h00, done_q});
      check_val("acc_q", {1'b0, acc_m}, {1'b0, acc_q});
      check_val("flags_q", {4'h0, flags_m}, {4'h0, flags_q});
      check_val("latch", {1'b0, latch_m}, {1'b0, table_high_latch_q});
      check_val("mem_wr_q.en", {8'h00, wr}, {8'h00, mem_wr_q.en});
      if (wr)
      begin
         check_val("mem_wr_q.addr", a, mem_wr_q.addr);
         check_val("mem_wr_q.data", {1'b0, r}, {1'b0, mem_wr_q.data});
      end
   endtask

   task automatic idle;
      instr.valid = 1'b0;
      @(negedge clock);
      check_val("done_q idle", 9'h000, {8'h00, done_q});
   endtask

   task automatic seed(input logic [1:0] sec, input logic [6:0] off, input logic [15:0] pw);
      cur_section = sec;
      exec(OP_TABLE_READ, ~sec, off, 8'h00, pw, 3'h0);
   endtask

   task automatic s_table;
      seed(2'h1, 7'h03, 16'hc35a);
      seed(2'h2, 7'h05, 16'h8001);
      seed(2'h3, 7'h07, 16'h3c80);
      seed(2'h0, 7'h09, 16'h00ff);
      idle();
   endtask

   // instr.section is set away from cur_section: ordinary ops must ignore it
   task automatic s_xor;
      cur_section = 2'h1;
      exec(OP_XOR_IMM, 2'h3, 7'h00, 8'h5a, 16'h0000, 3'h0);
      exec(OP_XOR_ACC, 2'h3, 7'h03, 8'h00, 16'h0000, 3'h0);
      exec(OP_XOR_IMM, 2'h3, 7'h00, 8'h0f, 16'h0000, 3'h0);
      exec(OP_XOR_TO_MEMORY, 2'h3, 7'h03, 8'h00, 16'h0000, 3'h0);
      exec(OP_XOR_ACC, 2'h3, 7'h03, 8'h00, 16'h0000, 3'h0);
      idle();
   endtask

   // operands chosen to hit signed wrap, nibble carry, carry out and zero
   task automatic s_add;
      cur_section = 2'h0;
      exec(OP_XOR_IMM, 2'h0, 7'h00, 8'h25, 16'h0000, 3'h0);
      exec(OP_LONG_ADD_ACC, 2'h2, 7'h05, 8'h00, 16'h0000, 3'h0);
      exec(OP_LONG_ADD_MEM, 2'h3, 7'h07, 8'h00, 16'h0000, 3'h0);
      exec(OP_LONG_ADD_CARRY_ACC, 2'h0, 7'h09, 8'h00, 16'h0000, 3'h0);
      exec(OP_LONG_ADD_CARRY_MEM, 2'h1, 7'h03, 8'h00, 16'h0000, 3'h0);
      exec(OP_LONG_ADD_CARRY_ACC, 2'h3, 7'h07, 8'h00, 16'h0000, 3'h0);
      // carry out of a plain add feeds straight into the next add with carry
      exec(OP_LONG_ADD_ACC, 2'h0, 7'h09, 8'h00, 16'h0000, 3'h0);
      exec(OP_LONG_ADD_CARRY_ACC, 2'h2, 7'h05, 8'h00, 16'h0000, 3'h0);
      idle();
   endtask

   task automatic s_and;
      exec(OP_LONG_AND_ACC, 2'h1, 7'h03, 8'h00, 16'h0000, 3'h0);
      exec(OP_LONG_AND_MEM, 2'h2, 7'h05, 8'h00, 16'h0000, 3'h0);
      exec(OP_NOP, 2'h0, 7'h00, 8'hff, 16'hffff, 3'h0);
      idle();
   endtask

   task automatic s_clear;
      seed(2'h2, 7'h0a, 16'h11ff);
      cur_section = 2'h0;
      for (int i = 0; i < 8; i++)
         exec(OP_LONG_CLEAR_BIT, 2'h2, 7'h0a, 8'h00, 16'h0000, 3'(i));
      exec(OP_LONG_CLEAR_BYTE, 2'h1, 7'h03, 8'h00, 16'h0000, 3'h0);
      idle();
   endtask

   task automatic wrap_up;
      $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
      if (n_mismatch == 0 && samples_checked > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask

   initial
   begin
      reset = 1'b1;
      instr = '0;
      cur_section = 2'h0;
      n_mismatch = 0;
      samples_checked = 0;
      acc_m = 8'h00;
      latch_m = 8'h00;
      flags_m = '0;
      repeat (16) @(negedge clock);
      reset = 1'b0;
      @(negedge clock);
      check_val("reset acc", 9'h000, {1'b0, acc_q});
      check_val("reset flags", 9'h000, {4'h0, flags_q});
      check_val("reset latch", 9'h000, {1'b0, table_high_latch_q});
      check_val("reset wr en", 9'h000, {8'h00, mem_wr_q.en});
      s_table();
      s_xor();
      s_add();
      s_and();
      s_clear();
      wrap_up();
   end

   // the sequence needs well under 100 cycles; this limit is far past it
   initial
   begin
      #20000;
      n_mismatch++;
      wrap_up();
   end
endmodule

`default_nettype wire
